// file: common/nv_access_if.sv
// Purpose: Joins the core side and the access control side
// Assumes: One clock, signals change after the rising edge
// Notes:   Read data stands in the cycle after the read strobe
`timescale 1ns/1ps
interface nv_access_if;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       halt;
   logic       irq;
   logic       selfprog_active;

   modport core
   (
      output addr,
      output wdata,
      output wr,
      output rd,
      output selfprog_active,
      input  rdata,
      input  halt,
      input  irq
   );

   modport dev
   (
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      input  selfprog_active,
      output rdata,
      output halt,
      output irq
   );
endinterface : nv_access_if

// file: common/nv_access_pkg.sv
// Purpose: Shared constants for the nonvolatile byte store access control
// Assumes: Single clock mclk at 50 MHz, synchronous active-high reset
// Notes:   Control register bit layout and timing counts live here
package nv_access_pkg;
   // ****************************************
   // Control register layout
   // ****************************************
   localparam int unsigned READ_STROBE_BIT  = 0;
   localparam int unsigned WRITE_STROBE_BIT = 1;
   localparam int unsigned WRITE_ARM_BIT    = 2;
   localparam int unsigned READY_IRQ_BIT    = 3;
   localparam int unsigned OP_SELECT_LO_BIT = 4;
   localparam int unsigned OP_SELECT_HI_BIT = 5;
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam logic [7:0]  CTRL_WMASK       = 8'h3f;

   // ****************************************
   // Register indices on the core port
   // ****************************************
   localparam logic [1:0]  IDX_CTRL         = 2'h0;
   localparam logic [1:0]  IDX_VALUE        = 2'h1;
   localparam logic [1:0]  IDX_PTR_LO       = 2'h2;
   localparam logic [1:0]  IDX_PTR_HI       = 2'h3;

   // ****************************************
   // Programming operations
   // ****************************************
   typedef enum logic [1:0]
   {
      OP_ERASE_WRITE = 2'h0,
      OP_ERASE_ONLY  = 2'h1,
      OP_WRITE_ONLY  = 2'h2,
      OP_RESERVED    = 2'h3
   } prog_op_t;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned ARM_WINDOW_CYCLES  = 4;
   localparam int unsigned WRITE_HALT_CYCLES  = 2;
   localparam int unsigned READ_HALT_CYCLES   = 4;
   localparam int unsigned WRITE_OSC_CYCLES   = 26368;
   localparam int unsigned ERASE_WRITE_US     = 3400;
   localparam int unsigned SPLIT_OP_US        = 1800;
   localparam int unsigned ADDR_BITS          = 12;
endpackage : nv_access_pkg

// file: src/nv_access_core.sv
// Purpose: Core-side sequencer that writes and reads one byte through the port
// Assumes: Commands arrive as one-cycle pulses; halt stalls the sequence
// Notes:   Keeps the arm-then-strobe pair back to back
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module nv_access_core
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        cmd_write,
   input  wire logic        cmd_read,
   input  wire logic [11:0] cmd_addr,
   input  wire logic [7:0]  cmd_data,
   input  wire logic        flash_busy,
   output logic             cmd_busy,
   output logic             cmd_done,
   output logic [7:0]       cmd_rdata,
   nv_access_if.core        bus
);
   typedef enum logic [3:0]
   {
      S_IDLE  = 4'h0,
      S_POLL  = 4'h1,
      S_PGAP  = 4'h3,
      S_WAIT  = 4'h2,
      S_PLO   = 4'h6,
      S_PHI   = 4'h7,
      S_VAL   = 4'h5,
      S_ARM   = 4'h4,
      S_STRB  = 4'hc,
      S_SHOLD = 4'hd,
      S_STALL = 4'hf,
      S_RSTRB = 4'he,
      S_RHOLD = 4'ha,
      S_RVAL  = 4'hb,
      S_RGAP  = 4'h9,
      S_CAP   = 4'h8
   } step_t;

   typedef struct packed
   {
      step_t       step;
      logic        is_wr;
      logic [11:0] addr;
      logic [7:0]  data;
      logic [1:0]  a;
      logic [7:0]  wd;
      logic        wr;
      logic        rd;
      logic        busy;
      logic        done;
      logic [7:0]  rdata;
   } state_t;

   state_t st_reg;
   state_t st_next;

   always_comb
   begin
      st_next      = st_reg;
      st_next.wr   = 1'b0;
      st_next.rd   = 1'b0;
      st_next.done = 1'b0;
      case (st_reg.step)
         S_IDLE:
         begin
            if (cmd_write || cmd_read)
            begin
               st_next.is_wr = cmd_write;
               st_next.addr  = cmd_addr;
               st_next.data  = cmd_data;
               st_next.busy  = 1'b1;
               st_next.step  = S_POLL;
            end
         end
         S_POLL:
         begin
            st_next.a    = nv_access_pkg::IDX_CTRL;
            st_next.rd   = 1'b1;
            st_next.step = S_PGAP;
         end
         S_PGAP:
         begin
            // Read data stands in the cycle after the read strobe
            st_next.step = S_WAIT;
         end
         S_WAIT:
         begin
            st_next.step = S_WAIT;
         end
         S_PLO:
         begin
            st_next.a    = nv_access_pkg::IDX_PTR_LO;
            st_next.wd   = st_reg.addr[7:0];
            st_next.wr   = 1'b1;
            st_next.step = S_PHI;
         end
         S_PHI:
         begin
            st_next.a    = nv_access_pkg::IDX_PTR_HI;
            st_next.wd   = {4'h0, st_reg.addr[11:8]};
            st_next.wr   = 1'b1;
            st_next.step = st_reg.is_wr ? S_VAL : S_RSTRB;
         end
         S_VAL:
         begin
            st_next.a    = nv_access_pkg::IDX_VALUE;
            st_next.wd   = st_reg.data;
            st_next.wr   = 1'b1;
            st_next.step = S_ARM;
         end
         S_ARM:
         begin
            st_next.a    = nv_access_pkg::IDX_CTRL;
            st_next.wd   = 8'h04;
            st_next.wr   = 1'b1;
            st_next.step = S_STRB;
         end
         S_STRB:
         begin
            st_next.wd   = 8'h02;
            st_next.wr   = 1'b1;
            st_next.step = S_SHOLD;
         end
         S_SHOLD:
         begin
            // Halt shows one cycle after the strobe is taken
            st_next.step = S_STALL;
         end
         S_RSTRB:
         begin
            st_next.a    = nv_access_pkg::IDX_CTRL;
            st_next.wd   = 8'h01;
            st_next.wr   = 1'b1;
            st_next.step = S_RHOLD;
         end
         S_RHOLD:
         begin
            st_next.step = S_RVAL;
         end
         S_RVAL:
         begin
            if (!bus.halt)
            begin
               st_next.a    = nv_access_pkg::IDX_VALUE;
               st_next.rd   = 1'b1;
               st_next.step = S_RGAP;
            end
         end
         S_RGAP:
         begin
            st_next.step = S_CAP;
         end
         S_CAP:
         begin
            st_next.rdata = bus.rdata;
            st_next.busy  = 1'b0;
            st_next.done  = 1'b1;
            st_next.step  = S_IDLE;
         end
         S_STALL:
         begin
            if (!bus.halt)
            begin
               st_next.busy = 1'b0;
               st_next.done = 1'b1;
               st_next.step = S_IDLE;
            end
         end
         default:
         begin
            st_next.step = S_IDLE;
         end
      endcase
      // Poll result: strobe clear and flash idle before any access
      if (st_reg.step == S_WAIT)
      begin
         if (!bus.rdata[nv_access_pkg::WRITE_STROBE_BIT] && !flash_busy)
         begin
            st_next.step = S_PLO;
         end
         else
         begin
            st_next.step = S_POLL;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign bus.addr            = st_reg.a;
   assign bus.wdata           = st_reg.wd;
   assign bus.wr              = st_reg.wr;
   assign bus.rd              = st_reg.rd;
   assign bus.selfprog_active = flash_busy;
   assign cmd_busy            = st_reg.busy;
   assign cmd_done            = st_reg.done;
   assign cmd_rdata           = st_reg.rdata;
endmodule : nv_access_core

// file: src/nv_access_ctrl.sv
// Purpose: Access control for the on-chip byte-wide nonvolatile store
// Assumes: Core port registers at indices 0..3, inputs synchronous to mclk
// Notes:   Write timing counts oscillator ticks given as a one-cycle pulse
`timescale 1ns/1ps
module nv_access_ctrl
#(
   parameter int unsigned DEPTH      = 4096,
   parameter int unsigned WRITE_TICKS = nv_access_pkg::WRITE_OSC_CYCLES
)
(
   input  wire logic  mclk,
   input  wire logic  rst,
   input  wire logic  osc_tick,
   input  wire logic  irq_global_en,
   nv_access_if.dev   bus
);
   localparam int unsigned AW = nv_access_pkg::ADDR_BITS;

   initial
   begin
      if (DEPTH < 2 || DEPTH > 4096 || WRITE_TICKS < 1 || WRITE_TICKS > 65535)
      begin
         $error("nv_access_ctrl: unsupported parameters");
      end
   end

   typedef struct packed
   {
      logic [AW-1:0] ptr;
      logic [7:0]    value;
      logic [1:0]    op;
      logic          irq_en;
      logic          arm;
      logic [2:0]    arm_cnt;
      logic          busy;
      logic [15:0]   tick_cnt;
      logic [2:0]    halt_cnt;
      logic [7:0]    rdata;
      logic          halt;
      logic          irq;
   } state_t;

   state_t        st_reg;
   state_t        st_next;
   logic [7:0]    mem [DEPTH];
   logic          mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0]    mem_wd;
   logic [7:0]    ctrl_view;
   logic [AW-1:0] ptr_lo_new;
   logic [AW-1:0] ptr_hi_new;

   // ****************************************
   // Register file and sequencing
   // ****************************************
   always_comb
   begin
      st_next   = st_reg;
      mem_we    = 1'b0;
      mem_wa    = st_reg.ptr;
      mem_wd    = st_reg.value;
      ctrl_view = {2'h0, st_reg.op, st_reg.irq_en, st_reg.arm, st_reg.busy, 1'b0};
      ptr_lo_new = {st_reg.ptr[AW-1:8], bus.wdata};
      ptr_hi_new = {bus.wdata[AW-9:0], st_reg.ptr[7:0]};

      // Arm window
      if (st_reg.arm)
      begin
         if (st_reg.arm_cnt == 3'(nv_access_pkg::ARM_WINDOW_CYCLES - 1))
         begin
            st_next.arm     = 1'b0;
            st_next.arm_cnt = 3'h0;
         end
         else
         begin
            st_next.arm_cnt = st_reg.arm_cnt + 3'h1;
         end
      end

      // Programming time
      if (st_reg.busy && osc_tick)
      begin
         if (st_reg.tick_cnt == 16'(WRITE_TICKS - 1))
         begin
            st_next.busy     = 1'b0;
            st_next.tick_cnt = 16'h0000;
            mem_we           = 1'b1;
            case (nv_access_pkg::prog_op_t'(st_reg.op))
               nv_access_pkg::OP_ERASE_WRITE: mem_wd = st_reg.value;
               nv_access_pkg::OP_ERASE_ONLY:  mem_wd = 8'hff;
               nv_access_pkg::OP_WRITE_ONLY:  mem_wd = mem[st_reg.ptr] & st_reg.value;
               default:                       mem_we = 1'b0;
            endcase
         end
         else
         begin
            st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
         end
      end

      // Halt counter
      if (st_reg.halt_cnt != 3'h0)
      begin
         st_next.halt_cnt = st_reg.halt_cnt - 3'h1;
      end

      if (bus.wr)
      begin
         case (bus.addr)
            nv_access_pkg::IDX_CTRL:
            begin
               st_next.irq_en = bus.wdata[nv_access_pkg::READY_IRQ_BIT];
               if (!st_reg.busy)
               begin
                  st_next.op = bus.wdata[nv_access_pkg::OP_SELECT_HI_BIT -: 2];
               end
               if (bus.wdata[nv_access_pkg::WRITE_STROBE_BIT])
               begin
                  // Strobe inside arm window, not busy, flash idle
                  if (st_reg.arm && !st_reg.busy && !bus.selfprog_active)
                  begin
                     st_next.busy     = 1'b1;
                     st_next.tick_cnt = 16'h0000;
                     st_next.arm      = 1'b0;
                     st_next.arm_cnt  = 3'h0;
                     st_next.halt_cnt = 3'(nv_access_pkg::WRITE_HALT_CYCLES);
                  end
               end
               else if (bus.wdata[nv_access_pkg::WRITE_ARM_BIT])
               begin
                  st_next.arm     = 1'b1;
                  st_next.arm_cnt = 3'h0;
               end
               if (bus.wdata[nv_access_pkg::READ_STROBE_BIT] && !st_reg.busy)
               begin
                  st_next.value    = mem[st_reg.ptr];
                  st_next.halt_cnt = 3'(nv_access_pkg::READ_HALT_CYCLES);
               end
            end
            nv_access_pkg::IDX_VALUE:
            begin
               st_next.value = bus.wdata;
            end
            nv_access_pkg::IDX_PTR_LO:
            begin
               if (!st_reg.busy)
               begin
                  st_next.ptr = ptr_lo_new;
               end
            end
            default:
            begin
               if (!st_reg.busy)
               begin
                  st_next.ptr = ptr_hi_new;
               end
            end
         endcase
      end

      if (bus.rd)
      begin
         case (bus.addr)
            nv_access_pkg::IDX_CTRL:   st_next.rdata = ctrl_view;
            nv_access_pkg::IDX_VALUE:  st_next.rdata = st_reg.value;
            nv_access_pkg::IDX_PTR_LO: st_next.rdata = st_reg.ptr[7:0];
            default:                   st_next.rdata = {4'h0, st_reg.ptr[AW-1:8]};
         endcase
      end
      else
      begin
         st_next.rdata = 8'h00;
      end

      st_next.halt = (st_next.halt_cnt != 3'h0);
      st_next.irq  = st_next.irq_en && irq_global_en && !st_next.busy;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg          <= '0;
         st_reg.ptr      <= st_reg.ptr;
         st_reg.value    <= st_reg.value;
         // Reset does not abort a write already underway; unknown busy clears
         if (st_reg.busy)
         begin
            st_reg.busy     <= 1'b1;
            st_reg.tick_cnt <= st_reg.tick_cnt;
            st_reg.op       <= st_reg.op;
         end
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Storage array
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (mem_we && !rst)
      begin
         mem[mem_wa[$clog2(DEPTH)-1:0]] <= mem_wd;
      end
   end

   assign bus.rdata = st_reg.rdata;
   assign bus.halt  = st_reg.halt;
   assign bus.irq   = st_reg.irq;
endmodule : nv_access_ctrl

// file: testbench/nv_access_asserts.sv
// Purpose: Assertions on the register port between core and control
// Assumes: One clock mclk, synchronous active-high rst
// Notes:   Arm age counts cycles since the last arming write
`timescale 1ns/1ps
module nv_access_asserts
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       halt,
   input wire logic       irq,
   input wire logic       selfprog_active
);
   logic       ctl_wr;
   logic [2:0] arm_age_reg;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   assign ctl_wr = wr && addr == nv_access_pkg::IDX_CTRL;
   // Saturates at seven so a stale arm never looks fresh
   always_ff @(posedge mclk)
   begin
      if (rst)
         arm_age_reg <= 3'h7;
      else if (ctl_wr && wdata[2])
         arm_age_reg <= 3'h1;
      else if (arm_age_reg != 3'h7)
         arm_age_reg <= arm_age_reg + 3'h1;
   end
   sequence s_arm;
      ctl_wr && wdata[2] && !wdata[1];
   endsequence
   sequence s_strobe;
      ctl_wr && wdata[1];
   endsequence
   sequence s_read;
      ctl_wr && wdata[0] && !wdata[1];
   endsequence
   property p_arm_form;
      ctl_wr && wdata[2] |-> !wdata[1];
   endproperty
   a_arm_form: assert property (p_arm_form) else $error("arm write sets strobe");
   property p_strobe_window;
      s_strobe |-> arm_age_reg inside {[3'h1:3'h4]};
   endproperty
   a_strobe_window: assert property (p_strobe_window) else $error("strobe late");
   property p_no_arm_flash;
      s_arm |-> !selfprog_active;
   endproperty
   a_no_arm_flash: assert property (p_no_arm_flash) else $error("arm in flash");
   property p_write_halt;
      s_arm ##1 s_strobe |=> halt [*2] ##1 !halt;
   endproperty
   a_write_halt: assert property (p_write_halt) else $error("write halt");
   property p_read_halt;
      s_read ##1 halt |-> halt [*4] ##1 !halt;
   endproperty
   a_read_halt: assert property (p_read_halt) else $error("read halt");
   property p_halt_cause;
      $rose(halt) |-> $past(ctl_wr && (wdata[0] || (wdata[1] && arm_age_reg inside {[3'h1:3'h4]})));
   endproperty
   a_halt_cause: assert property (p_halt_cause) else $error("halt uncaused");
   property p_ctrl_read;
      rd && addr == nv_access_pkg::IDX_CTRL |=> !rdata[0] && rdata[7:6] == 2'h0;
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl readback");
   property p_ptr_hi_read;
      rd && addr == nv_access_pkg::IDX_PTR_HI |=> rdata[7:4] == 4'h0;
   endproperty
   a_ptr_hi_read: assert property (p_ptr_hi_read) else $error("ptr high");
endmodule : nv_access_asserts

// file: testbench/tb_eeprom_access_control.sv
// Purpose: Self-checking bench for the byte store access pair
// Assumes: 50 MHz mclk, reset held 16 cycles, short write tick count
// Notes:   A second control end is driven directly for refusal cases
`timescale 1ns/1ps
module tb_eeprom_access_control;
   localparam int unsigned WT = 4;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        osc_tick = 1'b0;
   logic        osc_tick2 = 1'b0;
   logic        irq_ge = 1'b1;
   logic        cmd_write = 1'b0;
   logic        cmd_read = 1'b0;
   logic [11:0] cmd_addr = 12'h000;
   logic [7:0]  cmd_data = 8'h00;
   logic        flash_busy = 1'b0;
   logic        cmd_busy;
   logic        cmd_done;
   logic [7:0]  cmd_rdata;
   int          mismatches = 0;
   int          tests_run = 0;
   logic [11:0] ad [8];
   logic [7:0]  dt [8];
   logic [7:0]  mv;
   logic [7:0]  d;
   nv_access_if bus1();
   nv_access_if bus2();
   nv_access_core nv_access_core_i (.mclk(mclk), .rst(rst), .cmd_write(cmd_write),
      .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .flash_busy(flash_busy),
      .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .bus(bus1.core));
   nv_access_ctrl #(.WRITE_TICKS(WT)) nv_access_ctrl_i (.mclk(mclk), .rst(rst),
      .osc_tick(osc_tick), .irq_global_en(irq_ge), .bus(bus1.dev));
   nv_access_ctrl #(.WRITE_TICKS(WT)) nv_access_ctrl_i2 (.mclk(mclk), .rst(rst),
      .osc_tick(osc_tick2), .irq_global_en(irq_ge), .bus(bus2.dev));
   nv_access_asserts nv_access_asserts_i (.mclk(mclk), .rst(rst), .addr(bus1.addr),
      .wdata(bus1.wdata), .wr(bus1.wr), .rd(bus1.rd), .rdata(bus1.rdata), .halt(bus1.halt),
      .irq(bus1.irq), .selfprog_active(bus1.selfprog_active));
   always #10 mclk = ~mclk;
   always @(posedge mclk)
      osc_tick <= ($urandom_range(2) == 0);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] next_byte(input logic [1:0] op, input logic [7:0] old,
                                            input logic [7:0] nw);
      case (op)
         nv_access_pkg::OP_ERASE_WRITE: return nw;
         nv_access_pkg::OP_ERASE_ONLY:  return 8'hff;
         nv_access_pkg::OP_WRITE_ONLY:  return old & nw;
         default:                       return old;
      endcase
   endfunction : next_byte
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask : chk
   task automatic conclude();
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic wait_done();
      for (int n = 0; cmd_done !== 1'b1; n++)
      begin
         if (n > 3000)
         begin
            chk("cmd_done", 12'h1, 12'h0);
            conclude();
         end
         @(posedge mclk);
      end
   endtask : wait_done
   task automatic do_cmd(input logic w, input logic [11:0] a, input logic [7:0] v);
      cmd_write <= w;
      cmd_read <= !w;
      cmd_addr <= a;
      cmd_data <= v;
      @(posedge mclk);
      cmd_write <= 1'b0;
      cmd_read <= 1'b0;
      @(posedge mclk);
      wait_done();
   endtask : do_cmd
   task automatic rw(input logic [1:0] a, input logic [7:0] v);
      bus2.addr <= a;
      bus2.wdata <= v;
      bus2.wr <= 1'b1;
      @(posedge mclk);
      bus2.wr <= 1'b0;
      @(posedge mclk);
   endtask : rw
   task automatic rr(input string nm, input logic [1:0] a, input logic [7:0] e);
      bus2.addr <= a;
      bus2.rd <= 1'b1;
      @(posedge mclk);
      bus2.rd <= 1'b0;
      @(posedge mclk);
      chk(nm, {4'h0, e}, {4'h0, bus2.rdata});
   endtask : rr
   task automatic tick();
      osc_tick2 <= 1'b1;
      @(posedge mclk);
      osc_tick2 <= 1'b0;
      @(posedge mclk);
   endtask : tick
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(85295));
      bus2.addr = 2'h0;
      bus2.wdata = 8'h00;
      bus2.wr = 1'b0;
      bus2.rd = 1'b0;
      bus2.selfprog_active = 1'b0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 8; i++)
      begin
         ad[i] = (i == 0) ? 12'h000 : (i == 7) ? 12'hfff : {3'(i), 9'($urandom)};
         dt[i] = (i == 0) ? 8'hff : (i == 7) ? 8'h00 : 8'($urandom);
         do_cmd(1'b1, ad[i], dt[i]);
      end
      for (int i = 7; i >= 0; i--)
      begin
         do_cmd(1'b0, ad[i], 8'h00);
         chk("core read", {4'h0, dt[i]}, {4'h0, cmd_rdata});
      end
      flash_busy <= 1'b1;
      do_cmd(1'b1, 12'h5a5, 8'h3c);
      do_cmd(1'b0, 12'h5a5, 8'h00);
      chk("flash busy write", 12'h3c, {4'h0, cmd_rdata});
      rw(nv_access_pkg::IDX_PTR_HI, 8'hff);
      rr("ptr high", nv_access_pkg::IDX_PTR_HI, 8'h0f);
      rw(nv_access_pkg::IDX_PTR_LO, 8'($urandom));
      rw(nv_access_pkg::IDX_CTRL, 8'h08);
      repeat (2) @(posedge mclk);
      chk("irq on", 12'h1, {11'h0, bus2.irq});
      irq_ge <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("irq masked", 12'h0, {11'h0, bus2.irq});
      irq_ge <= 1'b1;
      rw(nv_access_pkg::IDX_CTRL, 8'h0a);
      rr("unarmed strobe", nv_access_pkg::IDX_CTRL, 8'h08);
      rw(nv_access_pkg::IDX_CTRL, 8'h0c);
      rr("arm set", nv_access_pkg::IDX_CTRL, 8'h0c);
      repeat (3) @(posedge mclk);
      rr("arm lapsed", nv_access_pkg::IDX_CTRL, 8'h08);
      bus2.selfprog_active <= 1'b1;
      rw(nv_access_pkg::IDX_CTRL, 8'h0c);
      rw(nv_access_pkg::IDX_CTRL, 8'h0a);
      repeat (4) @(posedge mclk);
      rr("selfprog strobe", nv_access_pkg::IDX_CTRL, 8'h08);
      bus2.selfprog_active <= 1'b0;
      mv = 8'h00;
      for (int op = 0; op < 4; op++)
      begin
         d = 8'($urandom);
         mv = next_byte(2'(op), mv, d);
         rw(nv_access_pkg::IDX_VALUE, d);
         rw(nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'hc});
         rw(nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'ha});
         @(posedge mclk);
         rr("busy", nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'ha});
         chk("irq busy", 12'h0, {11'h0, bus2.irq});
         rw(nv_access_pkg::IDX_PTR_LO, 8'($urandom));
         rw(nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'hb});
         rr("value held", nv_access_pkg::IDX_VALUE, d);
         repeat (WT - 1) tick();
         rr("busy counts", nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'ha});
         tick();
         repeat (3) @(posedge mclk);
         rr("busy clear", nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'h8});
         rw(nv_access_pkg::IDX_CTRL, {2'h0, 2'(op), 4'h9});
         rr("stored byte", nv_access_pkg::IDX_VALUE, mv);
      end
      conclude();
   end
   initial
   begin
      for (int n = 0; n < 2000 && flash_busy !== 1'b1; n++)
      begin
         @(posedge mclk);
      end
      repeat (40) @(posedge mclk);
      chk("busy under flash", 12'h1, {11'h0, cmd_busy});
      chk("done under flash", 12'h0, {11'h0, cmd_done});
      flash_busy <= 1'b0;
   end
endmodule : tb_eeprom_access_control
